/* File: src/est_consts.svh */
`ifndef EST_CONSTS_SVH
`define EST_CONSTS_SVH
// ----------------------------------------
// Register byte offsets and word indexes
// ----------------------------------------
`define EST_A_CFG     12'h000
`define EST_A_CTRL    12'h004
`define EST_A_COUNT   12'h008
`define EST_A_STATE   12'h00c
`define EST_A_INPUT   12'h010
`define EST_A_OUTPUT  12'h014
`define EST_A_REGMODE 12'h018
`define EST_A_FLAGS   12'h01c
`define EST_A_LIMIT   12'h020
`define EST_A_HALT    12'h024
`define EST_A_STOP    12'h028
`define EST_A_START   12'h02c
`define EST_A_IRQEN   12'h030
`define EST_A_DMA0    12'h034
`define EST_A_DMA1    12'h038
`define EST_I_MC      10'd64
`define EST_I_CAPM    10'd80
`define EST_I_EV      10'd96
`define EST_I_OUT     10'd128
// ----------------------------------------
// Sizes
// ----------------------------------------
`define EST_N_EV      16
`define EST_N_MC      16
`define EST_N_IN      8
`define EST_N_OUT     10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define EST_CFG_UNIFY 0
`define EST_CFG_CLKIN 1
`define EST_CFG_INSEL 4:2
`define EST_CFG_AUTOL 8
`define EST_CTL_STOP  1
`define EST_CTL_HALT  2
`define EST_CTL_BIDIR 4
`define EST_CTL_HI    16
`define EST_EV_MSEL   3:0
`define EST_EV_HI     4
`define EST_EV_IOC    6:5
`define EST_EV_IOOUT  7
`define EST_EV_IOSEL  11:8
`define EST_EV_COMB   13:12
`define EST_EV_STLD   14
`define EST_EV_STV    19:15
`define EST_EV_HOLD   20
`define EST_EV_DIR    22:21
`define EST_EV_STEN   23
// ----------------------------------------
// Reset values
// ----------------------------------------
`define EST_RST_STOP  2'b11
`define EST_RST_UP    2'b11
`endif

/* File: src/est_pkg.sv */
package est_pkg;
   // ----------------------------------------
   // Bus carriers
   // ----------------------------------------
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } est_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } est_apb_rsp_type;

   // ----------------------------------------
   // Whole block state
   // ----------------------------------------
   typedef struct packed {
      logic [31:0]             cnt;
      logic [1:0]              up;
      logic [1:0]              stop;
      logic [1:0]              halt;
      logic [4:0]              st;
      logic [9:0]              outs;
      logic [9:0]              outp;
      logic [7:0]              inp;
      logic [31:0]             cfg;
      logic [1:0]              bidir;
      logic [3:0][31:0]        actm;
      logic [15:0]             regmode;
      logic [15:0][31:0]       mc;
      logic [15:0][15:0]       capm;
      logic [15:0][31:0]       evc;
      logic [15:0][31:0]       evs;
      logic [9:0][15:0]        osm;
      logic [9:0][15:0]        ocm;
      logic [15:0]             held;
      logic [15:0]             flags;
      logic [15:0]             irqen;
      logic [1:0][15:0]        dmam;
      logic                    irq;
      logic [1:0]              dma;
      est_apb_rsp_type         rsp;
   } est_state_type;
endpackage : est_pkg

/* File: src/est_timer.sv */
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "est_consts.svh"
module est_timer (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     resetn,
   // Register bus
   input  wire est_pkg::est_apb_req_type apb_req,
   output      est_pkg::est_apb_rsp_type apb_rsp,
   // Block pins
   input  wire logic [7:0]               ev_in,
   output      logic [9:0]               ev_out,
   // Requests
   output      logic                     irq,
   output      logic [1:0]               dma_req
);
   est_pkg::est_state_type r;
   est_pkg::est_state_type n;
   logic [15:0]            fire;
   logic [15:0]            mraw;
   logic                   tick;
   logic [9:0]             idx;
   logic                   wr;
   logic [31:0]            rd;
   logic                   hit;
   logic [32:0]            res0;
   logic [32:0]            res1;
   logic [1:0]             lim;
   logic [1:0]             run;
   logic                   unify;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Compare one counter against a pool entry; halves in split mode
   function automatic logic est_match(input logic [31:0] c, input logic [31:0] m,
                                      input logic uni, input logic hi);
      begin
         if (uni)
            return c == m;
         else if (hi)
            return c[31:16] == m[31:16];
         else
            return c[15:0] == m[15:0];
      end
   endfunction : est_match

   // Pick an input or an output by number; out-of-range outputs read low, inputs use the low three bits
   function automatic logic est_io(input logic [3:0] s, input logic isout,
                                   input logic [7:0] iv, input logic [9:0] ov);
      begin
         if (isout)
            return (s < 4'd10) ? ov[s] : 1'b0;
         else
            return iv[s[2:0]];
      end
   endfunction : est_io

   // One count step: returns {up, value}
   function automatic logic [32:0] est_step(input logic [31:0] c, input logic up,
                                            input logic bd, input logic lm,
                                            input logic wide);
      logic [31:0] msk;
      logic        nu;
      logic [31:0] v;
      begin
         msk = wide ? 32'hffffffff : 32'h0000ffff;
         if (!bd)
         begin
            nu = 1'b1;
            v  = lm ? 32'h00000000 : c + 32'h00000001;
         end
         else
         begin
            // Turning at zero avoids wrapping when counting down
            nu = lm ? !up : ((!up && c == 32'h00000000) ? 1'b1 : up);
            v  = nu ? c + 32'h00000001 : c - 32'h00000001;
         end
         return {nu, v & msk};
      end
   endfunction : est_step

   // ----------------------------------------
   // Event evaluation and actions
   // ----------------------------------------
   always_comb
   begin
      n       = r;
      unify   = r.cfg[`EST_CFG_UNIFY];
      idx     = apb_req.paddr[11:2];
      wr      = apb_req.psel & apb_req.penable & apb_req.pwrite & r.rsp.pready;
      fire    = 16'h0000;
      mraw    = 16'h0000;
      tick    = r.cfg[`EST_CFG_CLKIN] ?
                (ev_in[r.cfg[`EST_CFG_INSEL]] & !r.inp[r.cfg[`EST_CFG_INSEL]]) : 1'b1;
      for (int e = 0; e < `EST_N_EV; e++)
      begin
         logic [31:0] c;
         logic        hi;
         logic        io;
         logic        cur;
         logic        prv;
         logic        mh;
         logic        cmb;
         logic        dok;
         logic        dr;
         c   = r.evc[e];
         hi  = c[`EST_EV_HI] & !unify;
         mraw[e] = !r.regmode[c[`EST_EV_MSEL]] &
                   est_match(r.cnt, r.mc[c[`EST_EV_MSEL]], unify, hi);
         mh  = mraw[e] | r.held[e];
         cur = est_io(c[`EST_EV_IOSEL], c[`EST_EV_IOOUT], ev_in, r.outs);
         prv = est_io(c[`EST_EV_IOSEL], c[`EST_EV_IOOUT], r.inp, r.outp);
         case (c[`EST_EV_IOC])
            2'd0:    io = !cur;
            2'd1:    io = cur & !prv;
            2'd2:    io = !cur & prv;
            default: io = cur;
         endcase
         case (c[`EST_EV_COMB])
            2'd0:    cmb = mh | io;
            2'd1:    cmb = mh;
            2'd2:    cmb = io;
            default: cmb = mh & io;
         endcase
         dr = hi ? r.up[1] : r.up[0];
         case (c[`EST_EV_DIR])
            2'd1:    dok = dr;
            2'd2:    dok = !dr;
            default: dok = 1'b1;
         endcase
         // State mask gate; only on a tick
         fire[e] = tick & cmb & dok & r.evs[e][r.st];
         if (fire[e])
            n.held[e] = 1'b0;
         else if (c[`EST_EV_HOLD] & mraw[e] & tick)
            n.held[e] = 1'b1;
      end

      // Start, stop and halt per counter
      for (int k = 0; k < 2; k++)
      begin
         logic [15:0] lm;
         logic        au;
         lm = r.actm[0][16*k +: 16];
         au = r.cfg[`EST_CFG_AUTOL + k] & !r.regmode[0] &
              est_match(r.cnt, r.mc[0], unify, k == 1);
         lim[k] = (|(fire & lm)) | (au & tick);
         run[k] = !r.stop[k] & !r.halt[k];
         if (|(fire & r.actm[3][16*k +: 16]))
            n.stop[k] = 1'b0;
         if (|(fire & r.actm[2][16*k +: 16]))
            n.stop[k] = 1'b1;
         if (|(fire & r.actm[1][16*k +: 16]))
            n.halt[k] = 1'b1;
      end

      // One wide or two narrow counters
      res0 = est_step(unify ? r.cnt : {16'h0000, r.cnt[15:0]}, r.up[0],
                      r.bidir[0], lim[0], unify);
      res1 = est_step({16'h0000, r.cnt[31:16]}, r.up[1], r.bidir[1], lim[1], 1'b0);
      if (tick & run[0])
      begin
         n.up[0] = res0[32];
         if (unify)
            n.cnt = res0[31:0];
         else
            n.cnt[15:0] = res0[15:0];
      end
      if (tick & run[1] & !unify)
      begin
         n.up[1]      = res1[32];
         n.cnt[31:16] = res1[15:0];
      end

      // Set, clear, both toggles; PWM edges come from firing events
      for (int o = 0; o < `EST_N_OUT; o++)
      begin
         logic s;
         logic cl;
         s  = |(fire & r.osm[o]);
         cl = |(fire & r.ocm[o]);
         if (s & cl)
            n.outs[o] = !r.outs[o];
         else if (s)
            n.outs[o] = 1'b1;
         else if (cl)
            n.outs[o] = 1'b0;
      end

      // Capture into capture-mode entries; any event source
      for (int i = 0; i < `EST_N_MC; i++)
         if (r.regmode[i] & (|(fire & r.capm[i])))
            n.mc[i] = r.cnt;

      // State change, highest event wins; events only
      for (int e = 0; e < `EST_N_EV; e++)
         if (fire[e] & r.evc[e][`EST_EV_STEN])
            n.st = r.evc[e][`EST_EV_STLD] ? r.evc[e][`EST_EV_STV] :
                   5'(r.st + r.evc[e][`EST_EV_STV]);

      // Requests; DMA straight from the firing vector, interrupt from flags and irqen
      n.dma[0] = |(fire & r.dmam[0]);
      n.dma[1] = |(fire & r.dmam[1]);
      n.flags  = (r.flags & ~((wr && idx == `EST_A_FLAGS >> 2) ?
                              apb_req.pwdata[15:0] : 16'h0000)) | fire;
      n.irq    = |(r.flags & r.irqen);
      n.inp    = ev_in;
      n.outp   = r.outs;

      // ----------------------------------------
      // Register read mux
      // ----------------------------------------
      rd  = 32'h00000000;
      hit = 1'b1;
      case ({apb_req.paddr[11:2], 2'b00})
         `EST_A_CFG:     rd = r.cfg;
         `EST_A_CTRL:    rd = {11'h000, r.bidir[1], 1'b0, r.halt[1], r.stop[1], 1'b0,
                               11'h000, r.bidir[0], 1'b0, r.halt[0], r.stop[0], 1'b0};
         `EST_A_COUNT:   rd = r.cnt;
         `EST_A_STATE:   rd = {27'h0000000, r.st};
         `EST_A_INPUT:   rd = {24'h000000, r.inp};
         `EST_A_OUTPUT:  rd = {22'h000000, r.outs};
         `EST_A_REGMODE: rd = {16'h0000, r.regmode};
         `EST_A_FLAGS:   rd = {16'h0000, r.flags};
         `EST_A_LIMIT:   rd = r.actm[0];
         `EST_A_HALT:    rd = r.actm[1];
         `EST_A_STOP:    rd = r.actm[2];
         `EST_A_START:   rd = r.actm[3];
         `EST_A_IRQEN:   rd = {16'h0000, r.irqen};
         `EST_A_DMA0:    rd = {16'h0000, r.dmam[0]};
         `EST_A_DMA1:    rd = {16'h0000, r.dmam[1]};
         default:
         begin
            if (idx >= `EST_I_MC && idx < `EST_I_CAPM)
               rd = r.mc[idx[3:0]];
            else if (idx >= `EST_I_CAPM && idx < `EST_I_EV)
               rd = {16'h0000, r.capm[idx[3:0]]};
            else if (idx >= `EST_I_EV && idx < `EST_I_OUT)
               rd = idx[0] ? r.evs[idx[4:1]] : r.evc[idx[4:1]];
            else if (idx >= `EST_I_OUT && idx < `EST_I_OUT + 10'd20)
               rd = {16'h0000, idx[0] ? r.ocm[5'(idx - `EST_I_OUT) >> 1]
                                      : r.osm[5'(idx - `EST_I_OUT) >> 1]};
            else
               hit = 1'b0;
         end
      endcase

      // ----------------------------------------
      // Register writes, after hardware updates
      // ----------------------------------------
      if (wr)
      begin
         case ({apb_req.paddr[11:2], 2'b00})
            `EST_A_CFG:     n.cfg = apb_req.pwdata;
            `EST_A_CTRL:
            begin
               for (int k = 0; k < 2; k++)
               begin
                  n.stop[k]  = apb_req.pwdata[`EST_CTL_STOP + 16*k];
                  n.halt[k]  = apb_req.pwdata[`EST_CTL_HALT + 16*k];
                  n.bidir[k] = apb_req.pwdata[`EST_CTL_BIDIR + 16*k];
               end
            end
            `EST_A_COUNT:   n.cnt = apb_req.pwdata;
            `EST_A_STATE:   n.st = apb_req.pwdata[4:0];
            `EST_A_OUTPUT:  n.outs = apb_req.pwdata[9:0];
            `EST_A_REGMODE: n.regmode = apb_req.pwdata[15:0];
            `EST_A_LIMIT:   n.actm[0] = apb_req.pwdata;
            `EST_A_HALT:    n.actm[1] = apb_req.pwdata;
            `EST_A_STOP:    n.actm[2] = apb_req.pwdata;
            `EST_A_START:   n.actm[3] = apb_req.pwdata;
            `EST_A_IRQEN:   n.irqen = apb_req.pwdata[15:0];
            `EST_A_DMA0:    n.dmam[0] = apb_req.pwdata[15:0];
            `EST_A_DMA1:    n.dmam[1] = apb_req.pwdata[15:0];
            default:
            begin
               if (idx >= `EST_I_MC && idx < `EST_I_CAPM)
                  n.mc[idx[3:0]] = apb_req.pwdata;
               else if (idx >= `EST_I_CAPM && idx < `EST_I_EV)
                  n.capm[idx[3:0]] = apb_req.pwdata[15:0];
               else if (idx >= `EST_I_EV && idx < `EST_I_OUT && idx[0])
                  n.evs[idx[4:1]] = apb_req.pwdata;
               else if (idx >= `EST_I_EV && idx < `EST_I_OUT)
                  n.evc[idx[4:1]] = apb_req.pwdata;
               else if (idx >= `EST_I_OUT && idx < `EST_I_OUT + 10'd20 && idx[0])
                  n.ocm[5'(idx - `EST_I_OUT) >> 1] = apb_req.pwdata[15:0];
               else if (idx >= `EST_I_OUT && idx < `EST_I_OUT + 10'd20)
                  n.osm[5'(idx - `EST_I_OUT) >> 1] = apb_req.pwdata[15:0];
            end
         endcase
      end

      // One wait-free access: ready is raised in the cycle after setup
      n.rsp.pready  = apb_req.psel & !apb_req.penable;
      n.rsp.prdata  = (apb_req.psel & !apb_req.penable) ? rd : 32'h00000000;
      n.rsp.pslverr = apb_req.psel & !apb_req.penable & !hit;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         r      <= '0;
         r.stop <= `EST_RST_STOP;
         r.up   <= `EST_RST_UP;
      end
      else
         r <= n;
   end

   assign apb_rsp = r.rsp;
   assign ev_out  = r.outs;
   assign irq     = r.irq;
   assign dma_req = r.dma;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_setup;
      apb_req.psel && !apb_req.penable;
   endsequence

   sequence s_ready;
      r.rsp.pready;
   endsequence

   a_apb_ready: assert property (s_setup |=> s_ready)
      else $error("ready not raised after setup");
   a_halt_sticky: assert property (r.halt[0] && !(wr && idx == 10'd1) |=> r.halt[0])
      else $error("halt dropped without software");
   a_limit_clear: assert property (tick && run[0] && lim[0] && !unify && !r.bidir[0]
                                   && !wr |=> r.cnt[15:0] == 16'h0000)
      else $error("limit did not clear counter");
   a_dir_flip: assert property (tick && run[0] && lim[0] && r.bidir[0] && !wr
                                |=> r.up[0] != $past(r.up[0]))
      else $error("limit did not reverse direction");
   a_out_set: assert property ((|(fire & r.osm[0])) && !(|(fire & r.ocm[0])) && !wr
                               |=> ev_out[0])
      else $error("output not set by event");
   a_cap_load: assert property (r.regmode[1] && (|(fire & r.capm[1])) && !wr
                                |=> r.mc[1] == $past(r.cnt))
      else $error("capture missed");
   a_irq_follow: assert property ((|(r.flags & r.irqen)) |=> irq ##1 1'b1)
      else $error("interrupt not raised");
   a_state_hold: assert property (fire == 16'h0000 && !wr |=> $stable(r.st))
      else $error("state changed without event");
   a_state_gate: assert property (fire[0] |-> r.evs[0][r.st] && tick)
      else $error("event fired outside its states");
   a_auto_limit: assert property (r.cfg[`EST_CFG_AUTOL] && !r.regmode[0] && !unify
                                  && !r.bidir[0] && tick && run[0] && !wr
                                  && r.cnt[15:0] == r.mc[0][15:0]
                                  |=> r.cnt[15:0] == 16'h0000)
      else $error("auto limit failed");
endmodule : est_timer

/* File: tb/est_pin_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Input sources and output loads
// ----------------------------------------
module est_pin_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Block pins
   input  wire logic [9:0] ev_out,
   output      logic [7:0] ev_in
);
   int   rises;
   logic o0_q;

   initial ev_in = 8'h00;

   // Load on output 0 counts its rising edges
   always @(posedge clk or negedge resetn)
      if (!resetn)
      begin
         rises <= 0;
         o0_q  <= 1'b0;
      end
      else
      begin
         o0_q <= ev_out[0];
         if (ev_out[0] && !o0_q)
            rises <= rises + 1;
      end

   // Idle pattern, changed just after an edge
   task set_idle(input logic [7:0] v);
      @(posedge clk);
      ev_in <= v;
   endtask : set_idle

   // Pulse held several cycles so a synchroniser never misses it
   task pulse(input int idx);
      @(posedge clk);
      ev_in[idx] <= 1'b1;
      repeat (4) @(posedge clk);
      ev_in[idx] <= 1'b0;
   endtask : pulse
endmodule : est_pin_model

/* File: tb/test_event_driven_state_timer_pwm.sv */
`timescale 1ns/100ps
module test_event_driven_state_timer_pwm;
   logic                     clk;
   logic                     resetn;
   est_pkg::est_apb_req_type req;
   est_pkg::est_apb_rsp_type rsp;
   logic [7:0]               ev_in;
   logic [9:0]               ev_out;
   logic                     irq;
   logic [1:0]               dma_req;
   int                       bad_count, checked, cyc, dma_n;
   logic [31:0]              seed, m, q, q2;
   logic                     err;
   // Setup table: auto limit, match, capture, two events, masks
   logic [11:0] ca [13] = '{12'h000, 12'h100, 12'h018, 12'h144, 12'h180, 12'h184,
      12'h190, 12'h194, 12'h200, 12'h210, 12'h024, 12'h030, 12'h034};
   logic [31:0] cd [13] = '{32'h100, 32'h0, 32'h2, 32'h1, 32'h81d000, 32'h1,
      32'h2320, 32'h8, 32'h1, 32'h4, 32'h4, 32'h1, 32'h4};

   est_timer uut (.clk(clk), .resetn(resetn), .apb_req(req), .apb_rsp(rsp),
      .ev_in(ev_in), .ev_out(ev_out), .irq(irq), .dma_req(dma_req));
   est_pin_model pins (.clk(clk), .resetn(resetn), .ev_out(ev_out), .ev_in(ev_in));

   initial clk = 1'b0;
   always #4 clk = ~clk;

   // ----------------------------------------
   // Watchdog and DMA pulse count
   // ----------------------------------------
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (dma_req[0] === 1'b1)
         dma_n <= dma_n + 1;
      if (cyc == 20000)
      begin
         bad_count = bad_count + 1;
         finish_test();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : check_val

   task check_bit(input string nm, input logic e, input logic g);
      check_val(nm, {31'h0, e}, {31'h0, g});
   endtask : check_bit

   // APB cycle; request held until pready is sampled
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= w;
      req.paddr   <= a;
      req.pwdata  <= d;
      @(posedge clk);
      req.penable <= 1'b1;
      // Wait states are open-ended; only the watchdog ends a hang
      do
         @(posedge clk);
      while (rsp.pready !== 1'b1);
      q   = rsp.prdata;
      err = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   // Bounded wait for one output to go high
   task wait_out(input int b);
      int n;
      n = 0;
      while (ev_out[b] !== 1'b1 && n < 300)
      begin
         @(posedge clk);
         n++;
      end
   endtask : wait_out

   task finish_test;
      $display("Mismatches %0d, comparisons %0d", bad_count, checked);
      if (bad_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : finish_test

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      bad_count = 0;
      checked = 0;
      cyc = 0;
      dma_n = 0;
      resetn = 1'b0;
      req = '0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      seed = lfsr(32'ha12e);
      m = 32'h10 + (seed & 32'hf);
      cd[1] = m;
      pins.set_idle(seed[15:8] & 8'hf7);
      apb(1'b0, 12'h00c, 32'h0);
      check_val("state_rst", 32'h0, q);
      apb(1'b1, 12'h010, 32'hff);
      apb(1'b0, 12'h010, 32'h0);
      check_val("input", {24'h0, seed[15:8] & 8'hf7}, q);
      apb(1'b0, 12'h03c, 32'h0);
      check_bit("unmapped_err", 1'b1, err);
      seed = lfsr(seed);
      apb(1'b1, 12'h00c, {27'h0, seed[4:0]});
      apb(1'b0, 12'h00c, 32'h0);
      check_val("state_rw", {27'h0, seed[4:0]}, q);
      apb(1'b1, 12'h00c, 32'h0);
      foreach (ca[i])
         apb(1'b1, ca[i], cd[i]);
      // Start the low counter only; high half stays stopped
      apb(1'b1, 12'h004, 32'h0002_0000);
      wait_out(0);
      check_val("out_match", 32'h1, {22'h0, ev_out});
      apb(1'b0, 12'h00c, 32'h0);
      check_val("state_load", 32'h3, q);
      check_bit("irq_set", 1'b1, irq);
      apb(1'b0, 12'h01c, 32'h0);
      check_val("flags", 32'h1, q);
      apb(1'b0, 12'h104, 32'h0);
      check_val("capture", m, q);
      apb(1'b0, 12'h008, 32'h0);
      check_bit("auto_limit", 1'b1, q <= m);
      // Event 0 is masked out in state 3: no second rise, flag stays clear
      apb(1'b1, 12'h01c, 32'h1);
      repeat (m + 4) @(posedge clk);
      check_bit("irq_clr", 1'b0, irq);
      apb(1'b0, 12'h01c, 32'h0);
      check_val("flags_gated", 32'h0, q);
      check_val("load_rises", 32'h1, pins.rises);
      pins.pulse(3);
      wait_out(2);
      check_val("out_edge", 32'h5, {22'h0, ev_out});
      repeat (2) @(posedge clk);
      check_val("dma_pulses", 32'h1, dma_n);
      apb(1'b0, 12'h008, 32'h0);
      q2 = q;
      repeat (5) @(posedge clk);
      apb(1'b0, 12'h008, 32'h0);
      check_val("halted_count", q2, q);
      apb(1'b0, 12'h004, 32'h0);
      check_bit("halt_bit", 1'b1, q[2]);
      apb(1'b1, 12'h004, 32'h0002_0000);
      apb(1'b0, 12'h008, 32'h0);
      q2 = q;
      apb(1'b0, 12'h008, 32'h0);
      check_bit("runs_again", 1'b1, q != q2);
      // Two-way from the limit value: the first step turns the count down
      apb(1'b1, 12'h004, 32'h0002_0002);
      apb(1'b1, 12'h008, m);
      apb(1'b1, 12'h004, 32'h0002_0010);
      apb(1'b0, 12'h008, 32'h0);
      check_val("bidir_turn", m - 32'h1, q);
      apb(1'b0, 12'h008, 32'h0);
      check_val("bidir_down", m - 32'h4, q);
      finish_test();
   end
endmodule : test_event_driven_state_timer_pwm
